/* seq_pkg.sv */
package seq_pkg;

	// ********************************************************
	// Register word addresses (byte address divided by two).
	// ********************************************************
	localparam logic [3:0] W_INSTR_LO = 4'h0;
	localparam logic [3:0] W_INSTR_HI = 4'h7;
	localparam logic [3:0] W_CONFIG   = 4'h8;
	localparam logic [3:0] W_INTEN    = 4'h9;
	localparam logic [3:0] W_STATUS   = 4'ha;
	localparam logic [3:0] W_TIMER    = 4'hb;
	localparam logic [3:0] W_FIFO     = 4'hc;

	// ********************************************************
	// Instruction word fields.
	// ********************************************************
	localparam int I_LOOP  = 0;
	localparam int I_PAUSE = 1;
	localparam int I_TMR   = 8;
	localparam int I_EIGHT = 9;
	localparam int I_SYNC  = 10;
	localparam int I_WDOG  = 11;
	localparam int I_ACQ   = 12;

	// ********************************************************
	// Limit word fields.
	// ********************************************************
	localparam int L_SIGN = 8;
	localparam int L_DIR  = 9;

	// ********************************************************
	// Configuration word fields.
	// ********************************************************
	localparam int C_START = 0;
	localparam int C_RESET = 1;
	localparam int C_AZ    = 2;
	localparam int C_FCAL  = 3;
	localparam int C_STBY  = 4;
	localparam int C_CMASK = 5;
	localparam int C_AZE   = 6;
	localparam int C_SYNCO = 7;
	localparam int C_PTR   = 8;

	// ********************************************************
	// Interrupt enable fields and event bit order.
	// ********************************************************
	localparam int E_ADDR = 8;
	localparam int E_CNT  = 11;
	localparam int limit_violation_irq     = 0;
	localparam int instruction_reached_irq = 1;
	localparam int fifo_threshold_irq      = 2;
	localparam int zero_offset_done_irq    = 3;
	localparam int self_cal_done_irq       = 4;
	localparam int sequencer_pause_irq     = 5;
	localparam int supply_low_irq          = 6;
	localparam int wake_return_irq         = 7;

	// ********************************************************
	// Reset values and timing counts in clock cycles.
	// ********************************************************
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam int TMR_DIV  = 32;
	localparam int TMR_OVH  = 2;
	localparam int ACQ_12   = 9;
	localparam int ACQ_8    = 6;
	localparam int ACQ_STEP = 2;
	localparam int CONV_12  = 44;
	localparam int CONV_8   = 21;

	// ********************************************************
	// Sequencer states; codes match the documented numbering.
	// ********************************************************
	typedef enum logic [2:0] {
		ST_FETCH   = 3'b000,
		ST_DECODE  = 3'b001,
		ST_CAL     = 3'b010,
		ST_TIMER   = 3'b011,
		ST_CONV    = 3'b100,
		ST_STORE   = 3'b101,
		ST_COMPARE = 3'b110,
		ST_ACQ     = 3'b111
	} seq_state_type;

endpackage

/* adc_instruction_sequencer.sv */
`timescale 1ns/1ns
// Summary of operation
// - After the loop-bit instruction, return to instruction 0 while run stays set.
// - Timer wait only before instruction 0; others run back to back.
// - Raise FIFO threshold flag once stored results reach programmed count.
// - Draining FIFO words never clears the run bit.
// - Conversions push one result; watchdog steps push none.
// - Acquisition field bits 12-15 lengthen settling before conversion.
// - Interrupt enable holds instruction address that raises instruction flag.
// - Interrupt enable holds five-bit FIFO count for threshold flag.
// - Channel mask zero puts instruction number in result bits 13-15.
// - Sync configuration bit zero makes the sync pin an input.
// - Timer counts preset down once every 32 clocks.
// - Timer wait adds a fixed two-cycle overhead.
// - State 3 is timer run, state 2 calibration, entered only on request.
// - Bus width pin high gives byte access selected by address bit 0.
module adc_instruction_sequencer
	import seq_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int CAL_CYC    = 64,
	parameter int AZ_CYC     = 16
)
(
	// Clock and reset.
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Host bus, synchronous to the common clock.
	input  wire logic        cs_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [4:0]  addr_i,
	input  wire logic [15:0] data_i,
	output logic      [15:0] data_o,
	output logic             data_oe_n_o,
	input  wire logic        bus_width_select_i,
	// Converter core.
	input  wire logic [12:0] sample_i,
	output logic             conv_start_o,
	// Pins.
	input  wire logic        sync_i,
	output logic             sync_o,
	output logic             sync_oe_n_o,
	input  wire logic        supply_low_i,
	output logic             irq_o
);
	import seq_pkg::*;

	localparam int CW = 22;
	localparam int FA = $clog2(FIFO_DEPTH);

	// Merges a host write into a word, honouring byte access.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] d, input logic narrow, input logic hi);
		if (!narrow)
			merge = d;
		else if (hi)
			merge = {d[7:0], old[7:0]};
		else
			merge = {old[15:8], d[7:0]};
	endfunction

	// ********************************************************
	// Pin synchronisers.
	// ********************************************************
	logic [1:0] bw_s_r;
	logic [1:0] sy_s_r;
	logic [1:0] lo_s_r;
	logic       sy_d_r;
	logic       lo_d_r;

	// Two stages each; the second stage and, for sync and supply, its delayed copy feed logic.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bw_s_r <= 2'h0;
			sy_s_r <= 2'h0;
			lo_s_r <= 2'h0;
			sy_d_r <= 1'b0;
			lo_d_r <= 1'b0;
		end
		else
		begin
			bw_s_r <= {bw_s_r[0], bus_width_select_i};
			sy_s_r <= {sy_s_r[0], sync_i};
			lo_s_r <= {lo_s_r[0], supply_low_i};
			sy_d_r <= sy_s_r[1];
			lo_d_r <= lo_s_r[1];
		end
	end

	// ********************************************************
	// Host decode.
	// ********************************************************
	logic        narrow;
	logic        hi;
	logic [3:0]  wa;
	logic        wr_en;
	logic        rd_en;
	logic        is_ins;

	assign narrow = bw_s_r[1];
	assign hi     = addr_i[0] & narrow;
	assign wa     = addr_i[4:1];
	assign wr_en  = cs_i & wr_i;
	assign rd_en  = cs_i & rd_i;
	assign is_ins = wa <= W_INSTR_HI;

	// ********************************************************
	// Registers.
	// ********************************************************
	logic [15:0] ins_mem [16];
	logic [15:0] lim_mem [16];
	logic [15:0] cfg_r;
	logic [15:0] ien_r;
	logic [15:0] tmr_r;
	logic [7:0]  flags_r;
	logic [7:0]  evt;
	logic [1:0]  ptr;
	logic [15:0] mw;
	logic [3:0]  mi;
	logic        cal_fin;
	logic        pause_evt;
	logic        stby_d_r;

	assign ptr = cfg_r[C_PTR+1:C_PTR];
	// Bank 0 holds instructions, banks 1 and 2 the two limit words.
	assign mi  = {ptr[1], wa[2:0]};
	assign mw  = ptr == 2'h0 ? ins_mem[{1'b0, wa[2:0]}] : lim_mem[mi];

	// Instruction and limit memories; pointer selects the bank.
	always_ff @(posedge sys_clk_i)
	begin
		if (wr_en && is_ins && ptr == 2'h0)
			ins_mem[{1'b0, wa[2:0]}] <= merge(mw, data_i, narrow, hi);
		if (wr_en && is_ins && ptr != 2'h0)
			lim_mem[mi] <= merge(mw, data_i, narrow, hi);
	end

	// Configuration; hardware clears one-shot commands.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cfg_r <= RST_WORD;
		else
		begin
			if (wr_en && wa == W_CONFIG)
				cfg_r <= merge(cfg_r, data_i, narrow, hi);
			else
			begin
				// FIFO reads leave the run bit alone.
				cfg_r[C_RESET] <= 1'b0;
				if (pause_evt)
					cfg_r[C_START] <= 1'b0;
				if (cal_fin)
				begin
					cfg_r[C_FCAL] <= 1'b0;
					cfg_r[C_AZ]   <= 1'b0;
				end
			end
		end
	end

	// Interrupt enable and timer preset.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ien_r <= RST_WORD;
			tmr_r <= RST_WORD;
		end
		else
		begin
			if (wr_en && wa == W_INTEN)
				ien_r <= merge(ien_r, data_i, narrow, hi);
			if (wr_en && wa == W_TIMER)
				tmr_r <= merge(tmr_r, data_i, narrow, hi);
		end
	end

	// Sticky flags; write one clears, a new event wins.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			flags_r  <= 8'h00;
			irq_o    <= 1'b0;
			stby_d_r <= 1'b0;
		end
		else
		begin
			stby_d_r <= cfg_r[C_STBY];
			if (wr_en && wa == W_STATUS && !hi)
				flags_r <= (flags_r & ~data_i[7:0]) | evt;
			else
				flags_r <= flags_r | evt;
			irq_o <= |(flags_r & ien_r[7:0]);
		end
	end

	// ********************************************************
	// Sequencer.
	// ********************************************************
	seq_state_type st_r;
	logic [2:0]    idx_r;
	logic [CW-1:0] cnt_r;
	logic [15:0]   ins;
	logic [12:0]   res_r;
	logic          go;
	logic          tmr_go;
	logic          cal_req;
	logic [CW-1:0] tmr_len;
	logic [CW-1:0] acq_len;
	logic [CW-1:0] conv_len;
	logic          viol;
	logic          adv;
	logic          in_rdy;
	logic [8:0]    smp8;
	logic [15:0]   l1;
	logic [15:0]   l2;

	assign ins = ins_mem[{1'b0, idx_r}];
	// A sync-gated instruction waits for a sync edge only when input.
	assign go = cfg_r[C_START] && !cfg_r[C_STBY] &&
		(!(ins[I_SYNC] && !cfg_r[C_SYNCO]) || (sy_s_r[1] && !sy_d_r));
	assign tmr_go  = idx_r == 3'h0 && ins[I_TMR];
	assign cal_req = cfg_r[C_FCAL] | cfg_r[C_AZ] | cfg_r[C_AZE];
	// Preset times 32 plus the fixed overhead, less one.
	assign tmr_len = CW'(tmr_r) * CW'(TMR_DIV) + CW'(TMR_OVH - 1);
	// Settling grows with the acquisition field.
	assign acq_len = CW'(ins[I_EIGHT] ? ACQ_8 : ACQ_12) - CW'(1) +
		CW'(ins[15:I_ACQ]) * CW'(ACQ_STEP);
	assign conv_len = CW'(ins[I_EIGHT] ? CONV_8 : CONV_12) - CW'(1);
	assign adv = st_r == ST_COMPARE || (st_r == ST_STORE && in_rdy);
	assign pause_evt = adv && ins[I_PAUSE];
	assign cal_fin = st_r == ST_CAL && cnt_r == '0;

	// Watchdog compares 8 bits plus sign against both limits.
	assign smp8 = sample_i[12:4];
	assign l1 = lim_mem[{1'b0, idx_r}];
	assign l2 = lim_mem[{1'b1, idx_r}];
	assign viol =
		(l1[L_DIR] ? $signed(smp8) > $signed(l1[8:0])
			: $signed(smp8) < $signed(l1[8:0])) ||
		(l2[L_DIR] ? $signed(smp8) > $signed(l2[8:0])
			: $signed(smp8) < $signed(l2[8:0]));

	// Main sequencer flow; stops at fetch between instructions, or in store while the buffer is full.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r  <= ST_FETCH;
			idx_r <= 3'h0;
			cnt_r <= '0;
		end
		else if (cfg_r[C_RESET])
		begin
			st_r  <= ST_FETCH;
			idx_r <= 3'h0;
		end
		else
		begin
			case (st_r)
				ST_FETCH:
					if (go)
						st_r <= ST_DECODE;
				ST_DECODE:
					// Calibration and timer only when asked for.
					if (cal_req)
					begin
						st_r  <= ST_CAL;
						cnt_r <= CW'(cfg_r[C_FCAL] ? CAL_CYC - 1 : AZ_CYC - 1);
					end
					else if (tmr_go)
					begin
						st_r  <= ST_TIMER;
						cnt_r <= tmr_len;
					end
					else
					begin
						st_r  <= ST_ACQ;
						cnt_r <= acq_len;
					end
				ST_CAL:
					if (cnt_r == '0)
					begin
						st_r  <= tmr_go ? ST_TIMER : ST_ACQ;
						cnt_r <= tmr_go ? tmr_len : acq_len;
					end
					else
						cnt_r <= cnt_r - CW'(1);
				ST_TIMER:
					if (cnt_r == '0)
					begin
						st_r  <= ST_ACQ;
						cnt_r <= acq_len;
					end
					else
						cnt_r <= cnt_r - CW'(1);
				ST_ACQ:
					if (cnt_r == '0)
					begin
						// Watchdog steps skip conversion entirely.
						st_r  <= ins[I_WDOG] ? ST_COMPARE : ST_CONV;
						cnt_r <= conv_len;
					end
					else
						cnt_r <= cnt_r - CW'(1);
				ST_CONV:
					if (cnt_r == '0)
						st_r <= ST_STORE;
					else
						cnt_r <= cnt_r - CW'(1);
				ST_STORE, ST_COMPARE:
					if (adv)
					begin
						st_r  <= ST_FETCH;
						idx_r <= ins[I_LOOP] ? 3'h0 : idx_r + 3'h1;
					end
				default:
					st_r <= ST_FETCH;
			endcase
		end
	end

	// Result capture and converter and sync pin drive.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			res_r        <= 13'h0000;
			conv_start_o <= 1'b0;
			sync_o       <= 1'b0;
			sync_oe_n_o  <= 1'b1;
		end
		else
		begin
			if (st_r == ST_CONV && cnt_r == '0)
				res_r <= sample_i;
			conv_start_o <= st_r == ST_ACQ && cnt_r == '0 &&
				!ins[I_WDOG];
			sync_oe_n_o  <= !cfg_r[C_SYNCO];
			sync_o       <= st_r == ST_CONV;
		end
	end

	// ********************************************************
	// Two-entry buffer in front of the FIFO.
	// ********************************************************
	logic [15:0] buf_q [2];
	logic        bwp_r;
	logic        brp_r;
	logic [1:0]  bcnt_r;
	logic        in_val;
	logic [15:0] in_word;
	logic        out_val;
	logic        out_rdy;
	logic        pop;

	assign in_val  = st_r == ST_STORE;
	assign in_rdy  = bcnt_r != 2'h2;
	assign out_val = bcnt_r != 2'h0;
	// Instruction number tags the result when the mask bit is clear.
	assign in_word = cfg_r[C_CMASK] ? {{3{res_r[12]}}, res_r}
		: {idx_r, res_r};

	// A stalled FIFO stops the sequencer in the store state.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bwp_r  <= 1'b0;
			brp_r  <= 1'b0;
			bcnt_r <= 2'h0;
		end
		else
		begin
			if (in_val && in_rdy)
			begin
				buf_q[bwp_r] <= in_word;
				bwp_r        <= ~bwp_r;
			end
			if (out_val && out_rdy)
				brp_r <= ~brp_r;
			bcnt_r <= bcnt_r + 2'(in_val && in_rdy) - 2'(out_val && out_rdy);
		end
	end

	// ********************************************************
	// Result FIFO.
	// ********************************************************
	logic [15:0]   fifo_mem [FIFO_DEPTH];
	logic [FA-1:0] fwp_r;
	logic [FA-1:0] frp_r;
	logic [FA:0]   fcnt_r;
	logic [7:0]    hold_r;

	assign out_rdy = fcnt_r != (FA+1)'(FIFO_DEPTH);
	// Narrow access pops on the low byte only; high byte is held.
	assign pop = rd_en && wa == W_FIFO && !hi && fcnt_r != '0;

	// FIFO pointers and count; reset command empties it.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fwp_r  <= '0;
			frp_r  <= '0;
			fcnt_r <= '0;
			hold_r <= 8'h00;
		end
		else if (cfg_r[C_RESET])
		begin
			fwp_r  <= '0;
			frp_r  <= '0;
			fcnt_r <= '0;
		end
		else
		begin
			if (out_val && out_rdy)
			begin
				fifo_mem[fwp_r] <= buf_q[brp_r];
				fwp_r           <= fwp_r + FA'(1);
			end
			if (pop)
			begin
				frp_r  <= frp_r + FA'(1);
				hold_r <= fifo_mem[frp_r][15:8];
			end
			fcnt_r <= fcnt_r + (FA+1)'(out_val && out_rdy) - (FA+1)'(pop);
		end
	end

	// ********************************************************
	// Events.
	// ********************************************************
	always_comb
	begin
		evt = 8'h00;
		evt[limit_violation_irq] = st_r == ST_COMPARE && viol;
		// Instruction address field picks the reporting step.
		evt[instruction_reached_irq] = st_r == ST_FETCH && go &&
			idx_r == ien_r[E_ADDR+2:E_ADDR];
		// Five-bit count field sets the threshold.
		evt[fifo_threshold_irq] = ien_r[15:E_CNT] != 5'h00 &&
			fcnt_r >= (FA+1)'(ien_r[15:E_CNT]);
		evt[zero_offset_done_irq] = cal_fin && !cfg_r[C_FCAL];
		evt[self_cal_done_irq] = cal_fin && cfg_r[C_FCAL];
		evt[sequencer_pause_irq] = pause_evt;
		evt[supply_low_irq] = lo_s_r[1] && !lo_d_r;
		evt[wake_return_irq] = stby_d_r && !cfg_r[C_STBY];
	end

	// ********************************************************
	// Read path; data valid while the enable is low.
	// ********************************************************
	logic [15:0] rw;

	always_comb
	begin
		rw = 16'h0000;
		if (is_ins)
			rw = mw;
		else
			case (wa)
				W_CONFIG: rw = cfg_r;
				W_INTEN:  rw = ien_r;
				W_STATUS: rw = {2'h0, 6'(fcnt_r), flags_r};
				W_TIMER:  rw = tmr_r;
				W_FIFO:   rw = fifo_mem[frp_r];
				default:  rw = 16'h0000;
			endcase
	end

	// One registered cycle after the strobe the word is driven.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_o      <= 16'h0000;
			data_oe_n_o <= 1'b1;
		end
		else
		begin
			data_oe_n_o <= !rd_en;
			if (rd_en)
			begin
				if (!narrow)
					data_o <= rw;
				else if (wa == W_FIFO && hi)
					data_o <= {8'h00, hold_r};
				else
					data_o <= {8'h00, hi ? rw[15:8] : rw[7:0]};
			end
		end
	end

endmodule

/* seq_checker_assertions.sv */
`timescale 1ns/1ns
module seq_checker (
	// Clock and reset.
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// Host bus.
	input wire logic        cs_i,
	input wire logic        rd_i,
	input wire logic        wr_i,
	input wire logic [4:0]  addr_i,
	input wire logic [15:0] data_i,
	input wire logic [15:0] data_o,
	input wire logic        data_oe_n_o,
	input wire logic        bus_width_select_i,
	// Core and pins.
	input wire logic        conv_start_o,
	input wire logic        sync_o,
	input wire logic        sync_oe_n_o,
	input wire logic        irq_o
);
	logic       sync_drv_r;
	logic [7:0] mask_r;
	logic [2:0] narrow_r;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// Shadows of the sync direction bit and the event masks.
	always_ff @(posedge sys_clk_i or posedge rst_i)
		if (rst_i)
		begin
			sync_drv_r <= 1'b0;
			mask_r     <= 8'h00;
		end
		else if (cs_i && wr_i)
		begin
			if (addr_i == 5'h10)
				sync_drv_r <= data_i[7];
			if (addr_i == 5'h12)
				mask_r <= data_i[7:0];
		end

	// Counts how long the width pin has been high; the pin is
	// synchronised, so byte mode is trusted only after a margin.
	always_ff @(posedge sys_clk_i or posedge rst_i)
		if (rst_i)
			narrow_r <= 3'h0;
		else if (!bus_width_select_i)
			narrow_r <= 3'h0;
		else if (narrow_r != 3'h7)
			narrow_r <= narrow_r + 3'h1;

	a_read_answer: assert property (cs_i && rd_i |=> !data_oe_n_o)
		else $error("no answer after read strobe");
	a_oe_released: assert property (!(cs_i && rd_i) |=> data_oe_n_o)
		else $error("data driven without read strobe");
	a_unmapped_zero: assert property (
		cs_i && rd_i && addr_i[4:1] > 4'hc |=> data_o == 16'h0000)
		else $error("unmapped read not zero");
	a_byte_upper_zero: assert property (
		narrow_r >= 3'h5 && !data_oe_n_o |-> data_o[15:8] == 8'h00)
		else $error("upper byte set in byte mode");
	a_conv_spacing: assert property (
		conv_start_o |=> !conv_start_o [*8])
		else $error("conversion starts too close");
	a_sync_marks_conv: assert property (
		$rose(conv_start_o) |-> ##[0:1] sync_o)
		else $error("sync output missing in conversion");
	a_sync_is_input: assert property (
		!sync_drv_r && !$past(sync_drv_r) |-> sync_oe_n_o)
		else $error("sync pin driven while set as input");
	a_irq_masked: assert property (
		mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq_o)
		else $error("interrupt with all sources masked");
	a_sync_idle: assert property (
		sync_oe_n_o && !sync_o |=> !conv_start_o || sync_oe_n_o)
		else $error("sync direction changed unasked");
endmodule

bind adc_instruction_sequencer seq_checker u_seq_checker (
	.sys_clk_i, .rst_i, .cs_i, .rd_i, .wr_i, .addr_i, .data_i,
	.data_o, .data_oe_n_o, .bus_width_select_i, .conv_start_o,
	.sync_o, .sync_oe_n_o, .irq_o);

/* host_bus_model.sv */
`timescale 1ns/1ns
module host_bus_model (
	// Clock.
	input  wire logic        sys_clk_i,
	// Bus towards the device.
	output logic             cs_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [4:0]  addr_o,
	output logic      [15:0] data_o,
	input  wire logic [15:0] rdata_i
);
	// Idle bus at time zero.
	initial
	begin
		cs_o = 1'b0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 5'h1f;
		data_o = 16'h5a5a;
	end

	// One write; released lines show the inverse, never stale data.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		cs_o <= 1'b1;
		wr_o <= 1'b1;
		addr_o <= a;
		data_o <= d;
		@(posedge sys_clk_i);
		cs_o <= 1'b0;
		wr_o <= 1'b0;
		addr_o <= ~a;
		data_o <= ~d;
	endtask

	// One read; the answer is taken at the edge after the strobe is
	// sampled, when the registered word has settled.
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		cs_o <= 1'b1;
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge sys_clk_i);
		cs_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge sys_clk_i);
		d = rdata_i;
	endtask

	// Byte pair, low byte first so the high half is held, not lost.
	task automatic rd_pair(input logic [4:0] a, output logic [15:0] d);
		logic [15:0] lo;
		logic [15:0] hi;
		rd(a, lo);
		rd(a | 5'h01, hi);
		d = {hi[7:0], lo[7:0]};
	endtask
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
	import seq_pkg::*;
	localparam logic [12:0] SMP = 13'h0abc;
	localparam int G = CONV_12 + 3 + ACQ_12;
	logic        sys_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        bw_i = 1'b0;
	logic        supply_low = 1'b0;
	logic        cs_i, rd_i, wr_i, data_oe_n_o, irq_o;
	logic        conv_start_o, sync_o, sync_oe_n_o;
	logic [4:0]  addr_i;
	logic [15:0] data_i, data_o, rdat;
	int          errors = 0;
	int          comparisons = 0;
	int          np = 0;
	int          cyc = 0;
	int          tp[4];

	// ********************************************************
	// Clock, instances and pulse timing capture.
	// ********************************************************
	always #2 sys_clk_i = ~sys_clk_i;

	host_bus_model u_host_bus_model (
		.sys_clk_i(sys_clk_i), .cs_o(cs_i), .rd_o(rd_i), .wr_o(wr_i),
		.addr_o(addr_i), .data_o(data_i), .rdata_i(data_o));

	adc_instruction_sequencer #(.CAL_CYC(4), .AZ_CYC(2))
	u_adc_instruction_sequencer (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_i(cs_i),
		.rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .data_i(data_i),
		.data_o(data_o), .data_oe_n_o(data_oe_n_o),
		.bus_width_select_i(bw_i), .sample_i(SMP),
		.conv_start_o(conv_start_o), .sync_i(1'b0), .sync_o(sync_o),
		.sync_oe_n_o(sync_oe_n_o), .supply_low_i(supply_low),
		.irq_o(irq_o));

	// Records the cycle of the first four conversion starts.
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (conv_start_o === 1'b1 && np < 4)
		begin
			tp[np] <= cyc;
			np <= np + 1;
		end
	end

	// ********************************************************
	// Shared checking tasks.
	// ********************************************************
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		u_host_bus_model.rd(a, rdat);
		chk(rdat, exp);
	endtask

	// Starts one pass and polls until the pause bit stops it.
	task automatic run_pass(input logic [15:0] cmd);
		u_host_bus_model.wr(5'h10, cmd);
		rdat = cmd;
		for (int i = 0; i < 500 && rdat[0] !== 1'b0; i++)
			u_host_bus_model.rd(5'h10, rdat);
		chk(16'(rdat[0]), 16'h0000);
		if (rdat[0] !== 1'b0)
			give_verdict();
	endtask

	// ********************************************************
	// Main sequence.
	// ********************************************************
	initial
	begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// Reset values, then an unmapped word.
		for (int a = 5'h10; a <= 5'h16; a += 2)
			rd_chk(5'(a), RST_WORD);
		rd_chk(5'h1c, 16'h0000);
		$display("test reset done");

		// Timed loop: timer ahead of word 0, longer settling on word 1.
		u_host_bus_model.wr(5'h00, 16'h0100);
		u_host_bus_model.wr(5'h02, 16'h3001);
		u_host_bus_model.wr(5'h16, 16'h0002);
		u_host_bus_model.wr(5'h10, 16'h0001);
		for (int i = 0; i < 2000 && np < 4; i++)
			@(posedge sys_clk_i);
		if (np < 4)
		begin
			errors++;
			$display("Error at %0t: conversions stalled", $time);
			give_verdict();
		end
		chk(16'(tp[1] - tp[0]), 16'(G + 3 * ACQ_STEP));
		chk(16'(tp[2] - tp[1]), 16'(G + 2 * TMR_DIV + TMR_OVH));
		chk(16'(tp[3] - tp[2]), 16'(G + 3 * ACQ_STEP));
		rd_chk(5'h18, {3'd0, SMP});
		rd_chk(5'h18, {3'd1, SMP});
		u_host_bus_model.rd(5'h10, rdat);
		chk(16'(rdat[0]), 16'h0001);
		u_host_bus_model.wr(5'h10, 16'h0000);
		repeat (120) @(posedge sys_clk_i);
		u_host_bus_model.wr(5'h10, 16'h0002);
		$display("test timed loop done");

		// One paused pass with a watchdog step between two conversions.
		u_host_bus_model.wr(5'h00, 16'h0000);
		u_host_bus_model.wr(5'h02, 16'h0800);
		u_host_bus_model.wr(5'h04, 16'h0003);
		u_host_bus_model.wr(5'h10, 16'h0100);
		u_host_bus_model.wr(5'h02, 16'h0250);
		u_host_bus_model.wr(5'h10, 16'h0200);
		u_host_bus_model.wr(5'h02, 16'h0100);
		u_host_bus_model.wr(5'h10, 16'h0000);
		u_host_bus_model.wr(5'h12, 16'h1207);
		u_host_bus_model.wr(5'h14, 16'h00ff);
		run_pass(16'h0001);
		chk(16'(irq_o), 16'h0001);
		rd_chk(5'h14, 16'h0227);
		bw_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		u_host_bus_model.rd_pair(5'h18, rdat);
		chk(rdat, {3'd0, SMP});
		u_host_bus_model.rd_pair(5'h18, rdat);
		chk(rdat, {3'd2, SMP});
		$display("test paused pass done");

		// Byte access to the timer word, then a full-width read.
		u_host_bus_model.wr(5'h16, 16'h0034);
		u_host_bus_model.wr(5'h17, 16'h0012);
		rd_chk(5'h17, 16'h0012);
		bw_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rd_chk(5'h16, 16'h1234);
		u_host_bus_model.wr(5'h14, 16'h00ff);
		repeat (3) @(posedge sys_clk_i);
		chk(16'(irq_o), 16'h0000);
		$display("test byte access done");

		// Calibration, auto-zero, supply and wake events, all masked.
		u_host_bus_model.wr(5'h12, 16'h0000);
		run_pass(16'h0009);
		rd_chk(5'h14, 16'h0233);
		chk(16'(irq_o), 16'h0000);
		u_host_bus_model.wr(5'h14, 16'h00ff);
		u_host_bus_model.wr(5'h10, 16'h0010);
		supply_low <= 1'b1;
		run_pass(16'h0085);
		rd_chk(5'h14, 16'h04eb);
		chk(16'(sync_oe_n_o), 16'h0000);
		$display("test events done");
		give_verdict();
	end
endmodule
